// *** gcm_top.sv ***
// Two-wire port slice: general call, address mask, master Start with collision check.
// Assumes a classic Wishbone master and open-drain SCL/SDA wires resolved outside.
//
// How it works
// - Address 0x00 is the general call and is acknowledged when general call is enabled, whatever own address.
// - An all-zero address with write direction raises an interrupt and leaves the byte in the receive buffer.
// - In 10-bit mode a general call does not set the update-address flag and the next byte is data.
// - With address hold on, SCL is held low after the eighth falling edge until software releases it.
// - A mask bit of zero makes the matching received address bit a don't-care; a one needs an exact match.
// - Reset loads the address mask with all ones.
// - In 7-bit mode the mask covers received address bits seven to one.
// - In 10-bit mode the mask covers bits seven to zero of the low byte and not the high byte.
// - A Start requested while SDA or SCL is low is aborted, flags a bus collision and returns to idle.
// - A Start begins with both lines released; with SDA high the baud rate generator is loaded and counts.
// - SCL low while SDA is still high in the first count is a bus collision.
// - SDA low in the first count reloads the generator and drives SDA low early, with no collision.
// - Otherwise SDA goes low at count end, the generator reloads, SCL low is ignored, then SCL goes low.
package gcm_pkg;
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_OWN     = 8'h04;
  localparam logic [7:0]  ADR_MASK    = 8'h08;
  localparam logic [7:0]  ADR_RXBUF   = 8'h0C;
  localparam logic [7:0]  ADR_BRG     = 8'h10;
  localparam logic [7:0]  ADR_STATUS  = 8'h14;
  localparam logic [7:0]  ADR_INT_CLR = 8'h18;
  localparam logic [7:0]  ADR_INT_EN  = 8'h1C;
  // Control register bits
  localparam int          CB_GENERAL_CALL_ENABLE  = 0;
  localparam int          CB_ADDRESS_HOLD_ENABLE  = 1;
  localparam int          CB_TEN   = 2;
  localparam int          CB_ACKV  = 3;
  localparam int          CB_START = 4;
  localparam int          CB_REL   = 5;
  localparam int          CB_FREE  = 6;
  // Event bits in status, clear and enable
  localparam int          EV_ADDR  = 0;
  localparam int          EV_GC    = 1;
  localparam int          EV_DATA  = 2;
  localparam int          EV_BCL   = 3;
  localparam int          EV_START = 4;
  localparam int          EV_W     = 5;
  localparam int          ST_UA    = 8;
  localparam int          ST_HOLD  = 9;
  localparam int          ST_BUSY  = 10;
  localparam logic [7:0]  MASK_RST = 8'hFF;
  localparam logic [7:0]  MASK_7B  = 8'hFE;
  localparam logic [7:0]  GC_ADDR  = 8'h00;
  localparam logic [4:0]  TEN_HDR  = 5'h1E;
  localparam logic [7:0]  BRG_RST  = 8'h04;
  localparam logic [3:0]  BIT_LAST = 4'h8;
  localparam logic [3:0]  BIT_ACK  = 4'h9;
  localparam logic [9:0]  OWN_RST  = 10'h000;

  typedef struct packed {
    logic general_call_enable;       // general_call_enable
    logic address_hold_enable;       // address_hold_enable
    logic ten_bit;    // 10-bit addressing
    logic ack_value;  // acknowledge_value, 0 acknowledges
  } gcm_ctrl_type;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
    logic lvl;
  } gcm_pin_type;

  typedef enum logic [1:0] {
    SL_IDLE  = 2'b00,
    SL_ADDR  = 2'b01,
    SL_ADDR2 = 2'b10,
    SL_DATA  = 2'b11
  } gcm_sl_type;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_CNT1 = 2'b01,
    M_CNT2 = 2'b10,
    M_HELD = 2'b11
  } gcm_m_type;

  // Address compare where a zero mask bit is a don't-care
  function automatic logic gcm_masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    gcm_masked_eq = (((a ^ b) & m) == 8'h00);
  endfunction
endpackage

module gcm_top import gcm_pkg::*; (
  input  wire logic        clk_i,      // 10 MHz system clock
  input  wire logic        rst_i,      // Synchronous reset, active high
  input  wire logic        wb_cyc_i,   // Wishbone cycle
  input  wire logic        wb_stb_i,   // Wishbone strobe
  input  wire logic        wb_we_i,    // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,   // Byte address
  input  wire logic [3:0]  wb_sel_i,   // Byte lane selects
  input  wire logic [31:0] wb_dat_i,   // Write data
  output logic      [31:0] wb_dat_o,   // Read data
  output logic             wb_ack_o,   // Wishbone acknowledge
  output logic             irq_o,      // Level interrupt
  input  wire logic        scl_i,      // SCL wire level
  output logic             scl_o,      // SCL drive level, always low
  output logic             scl_oe_o,   // SCL pulled low when high
  input  wire logic        sda_i,      // SDA wire level
  output logic             sda_o,      // SDA drive level, always low
  output logic             sda_oe_o    // SDA pulled low when high
);
  logic [1:0]   pin_s;
  logic         scl_s, sda_s, scl_d, sda_d;
  logic         scl_rise, scl_fall, start_det, stop_det;
  // Register file state
  gcm_ctrl_type ctrl_reg, ctrl_next;
  logic [9:0]   own_reg, own_next;
  logic [7:0]   mask_reg, mask_next;
  logic [7:0]   brg_reg, brg_next;
  logic [EV_W-1:0] sts_reg, sts_next, en_reg, en_next, evt;
  logic         ua_reg, ua_next;
  logic         ack_reg, ack_next, irq_reg, irq_next;
  logic [31:0]  rdat_reg, rdat_next;
  logic         wr_en, start_pulse, rel_pulse, free_pulse;
  // Slave state
  gcm_sl_type   sl_state, sl_state_n;
  logic [3:0]   sl_cnt, sl_cnt_n;
  logic [7:0]   sl_shift, sl_shift_n, rxbuf_reg, rxbuf_next;
  logic         sl_ack, sl_ack_n, sl_hold, sl_hold_n, sl_match;
  logic         gc_evt, addr_evt, data_evt, ua_set;
  // Master state
  gcm_m_type    m_state, m_state_n;
  logic [7:0]   brg_cnt, brg_cnt_n;
  logic         m_sda_low, m_sda_low_n, m_scl_low, m_scl_low_n;
  logic         bcl_evt, start_evt;
  gcm_pin_type  pin_reg, pin_next;

  gcm_sync2 u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({scl_i, sda_i}),
    .pin_o (pin_s)
  );

  // Bus edges from synchronised levels
  assign scl_s     = pin_s[1];
  assign sda_s     = pin_s[0];
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & ~sda_s & sda_d;
  assign stop_det  = scl_s & scl_d & sda_s & ~sda_d;

  // Register file; writes commit on the edge that raises ack
  always_comb begin
    wr_en       = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg & wb_sel_i[0];
    ack_next    = wb_cyc_i & wb_stb_i & ~ack_reg;
    ctrl_next   = ctrl_reg;
    own_next    = own_reg;
    mask_next   = mask_reg;
    brg_next    = brg_reg;
    en_next     = en_reg;
    start_pulse = wr_en && wb_adr_i == ADR_CTRL && wb_dat_i[CB_START];
    rel_pulse   = wr_en && wb_adr_i == ADR_CTRL && wb_dat_i[CB_REL];
    free_pulse  = wr_en && wb_adr_i == ADR_CTRL && wb_dat_i[CB_FREE];
    if (wr_en) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          ctrl_next = '{general_call_enable: wb_dat_i[CB_GENERAL_CALL_ENABLE], address_hold_enable: wb_dat_i[CB_ADDRESS_HOLD_ENABLE],
                        ten_bit: wb_dat_i[CB_TEN], ack_value: wb_dat_i[CB_ACKV]};
        end
        ADR_OWN: begin
          own_next[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) begin
            own_next[9:8] = wb_dat_i[9:8];
          end
        end
        ADR_MASK:   mask_next = wb_dat_i[7:0];
        ADR_BRG:    brg_next  = wb_dat_i[7:0];
        ADR_INT_EN: en_next   = wb_dat_i[EV_W-1:0];
        default: begin
        end
      endcase
    end
    evt = '0;
    evt[EV_ADDR]  = addr_evt;
    evt[EV_GC]    = gc_evt;
    evt[EV_DATA]  = data_evt;
    evt[EV_BCL]   = bcl_evt;
    evt[EV_START] = start_evt;
    // A new event wins over a clear in the same cycle
    sts_next = evt | sts_reg;
    if (wr_en && wb_adr_i == ADR_INT_CLR) begin
      sts_next = evt | (sts_reg & ~wb_dat_i[EV_W-1:0]);
    end
    ua_next  = ua_set | (ua_reg & ~(wr_en && wb_adr_i == ADR_OWN));
    irq_next = |(sts_reg & en_reg);
    rdat_next = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL: begin
        rdat_next[CB_GENERAL_CALL_ENABLE] = ctrl_reg.general_call_enable;
        rdat_next[CB_ADDRESS_HOLD_ENABLE] = ctrl_reg.address_hold_enable;
        rdat_next[CB_TEN]  = ctrl_reg.ten_bit;
        rdat_next[CB_ACKV] = ctrl_reg.ack_value;
      end
      ADR_OWN:    rdat_next[9:0] = own_reg;
      ADR_MASK:   rdat_next[7:0] = mask_reg;
      ADR_RXBUF:  rdat_next[7:0] = rxbuf_reg;
      ADR_BRG:    rdat_next[7:0] = brg_reg;
      ADR_INT_EN: rdat_next[EV_W-1:0] = en_reg;
      ADR_STATUS: begin
        rdat_next[EV_W-1:0] = sts_reg;
        rdat_next[ST_UA]    = ua_reg;
        rdat_next[ST_HOLD]  = sl_hold;
        rdat_next[ST_BUSY]  = (m_state != M_IDLE);
      end
      default: rdat_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
      own_reg  <= OWN_RST;
      mask_reg <= MASK_RST;
      brg_reg  <= BRG_RST;
      en_reg   <= '0;
      sts_reg  <= '0;
      ua_reg   <= 1'b0;
      ack_reg  <= 1'b0;
      irq_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      own_reg  <= own_next;
      mask_reg <= mask_next;
      brg_reg  <= brg_next;
      en_reg   <= en_next;
      sts_reg  <= sts_next;
      ua_reg   <= ua_next;
      ack_reg  <= ack_next;
      irq_reg  <= irq_next;
      rdat_reg <= rdat_next;
    end
  end

  // Slave receiver: address compare, general call, clock hold, acknowledge
  always_comb begin
    sl_state_n = sl_state;
    sl_cnt_n   = sl_cnt;
    sl_shift_n = sl_shift;
    sl_ack_n   = sl_ack;
    sl_hold_n  = sl_hold;
    rxbuf_next = rxbuf_reg;
    sl_match   = 1'b0;
    gc_evt     = 1'b0;
    addr_evt   = 1'b0;
    data_evt   = 1'b0;
    ua_set     = 1'b0;
    if (start_det) begin
      sl_state_n = SL_ADDR;
      sl_cnt_n   = '0;
      sl_ack_n   = 1'b0;
      sl_hold_n  = 1'b0;
    end else if (stop_det) begin
      sl_state_n = SL_IDLE;
      sl_cnt_n   = '0;
      sl_ack_n   = 1'b0;
      sl_hold_n  = 1'b0;
    end else if (sl_state != SL_IDLE) begin
      if (sl_hold) begin
        // Software chose the acknowledge while the clock was stretched
        if (rel_pulse) begin
          sl_hold_n = 1'b0;
          sl_ack_n  = ~ctrl_reg.ack_value;
        end
      end else if (scl_rise && sl_cnt < BIT_LAST) begin
        sl_shift_n = {sl_shift[6:0], sda_s};
        sl_cnt_n   = sl_cnt + 4'h1;
      end else if (scl_fall && sl_cnt == BIT_LAST) begin
        case (sl_state)
          SL_ADDR: begin
            if (ctrl_reg.general_call_enable && sl_shift == GC_ADDR) begin
              sl_match   = 1'b1;
              gc_evt     = 1'b1;
              sl_state_n = SL_DATA;
            end else if (ctrl_reg.ten_bit) begin
              // High byte is compared exactly, mask not applied
              sl_match   = (sl_shift[7:1] == {TEN_HDR, own_reg[9:8]});
              sl_state_n = SL_ADDR2;
            end else begin
              sl_match   = gcm_masked_eq(sl_shift, own_reg[7:0], mask_reg & MASK_7B);
              sl_state_n = SL_DATA;
            end
          end
          SL_ADDR2: begin
            sl_match   = gcm_masked_eq(sl_shift, own_reg[7:0], mask_reg);
            ua_set     = sl_match;
            sl_state_n = SL_DATA;
          end
          SL_DATA: begin
            sl_match = 1'b1;
            data_evt = 1'b1;
          end
          default: sl_match = 1'b0;
        endcase
        if (sl_match) begin
          addr_evt   = (sl_state != SL_DATA);
          rxbuf_next = sl_shift;
          sl_cnt_n   = BIT_ACK;
          if (sl_state != SL_DATA && ctrl_reg.address_hold_enable) begin
            sl_hold_n = 1'b1;
          end else begin
            sl_ack_n = (sl_state != SL_DATA) | ~ctrl_reg.ack_value;
          end
        end else begin
          sl_state_n = SL_IDLE;
          sl_cnt_n   = '0;
        end
      end else if (scl_fall && sl_cnt == BIT_ACK) begin
        sl_ack_n = 1'b0;
        sl_cnt_n = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_state  <= SL_IDLE;
      sl_cnt    <= '0;
      sl_shift  <= 8'h00;
      sl_ack    <= 1'b0;
      sl_hold   <= 1'b0;
      rxbuf_reg <= 8'h00;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
    end else begin
      sl_state  <= sl_state_n;
      sl_cnt    <= sl_cnt_n;
      sl_shift  <= sl_shift_n;
      sl_ack    <= sl_ack_n;
      sl_hold   <= sl_hold_n;
      rxbuf_reg <= rxbuf_next;
      scl_d     <= scl_s;
      sda_d     <= sda_s;
    end
  end

  // Master Start generator; collision only before SDA is driven low
  always_comb begin
    m_state_n   = m_state;
    brg_cnt_n   = brg_cnt;
    m_sda_low_n = m_sda_low;
    m_scl_low_n = m_scl_low;
    bcl_evt     = 1'b0;
    start_evt   = 1'b0;
    case (m_state)
      M_IDLE: begin
        if (start_pulse) begin
          if (!scl_s || !sda_s) begin
            bcl_evt = 1'b1;
          end else begin
            brg_cnt_n = brg_reg;
            m_state_n = M_CNT1;
          end
        end
      end
      M_CNT1: begin
        if (!sda_s) begin
          brg_cnt_n   = brg_reg;
          m_sda_low_n = 1'b1;
          m_state_n   = M_CNT2;
        end else if (!scl_s) begin
          bcl_evt   = 1'b1;
          m_state_n = M_IDLE;
        end else if (brg_cnt == 8'h00) begin
          m_sda_low_n = 1'b1;
          brg_cnt_n   = brg_reg;
          m_state_n   = M_CNT2;
        end else begin
          brg_cnt_n = brg_cnt - 8'h01;
        end
      end
      M_CNT2: begin
        // SCL low here is another master's Start; not a collision
        if (brg_cnt == 8'h00) begin
          m_scl_low_n = 1'b1;
          start_evt   = 1'b1;
          m_state_n   = M_HELD;
        end else begin
          brg_cnt_n = brg_cnt - 8'h01;
        end
      end
      M_HELD: begin
        // Bus owned; arbitration on the address is left to the shifter
        if (free_pulse) begin
          m_sda_low_n = 1'b0;
          m_scl_low_n = 1'b0;
          m_state_n   = M_IDLE;
        end
      end
      default: m_state_n = M_IDLE;
    endcase
    pin_next.scl_oe = sl_hold | m_scl_low;
    pin_next.sda_oe = sl_ack | m_sda_low;
    pin_next.lvl    = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_state   <= M_IDLE;
      brg_cnt   <= 8'h00;
      m_sda_low <= 1'b0;
      m_scl_low <= 1'b0;
      pin_reg   <= '0;
    end else begin
      m_state   <= m_state_n;
      brg_cnt   <= brg_cnt_n;
      m_sda_low <= m_sda_low_n;
      m_scl_low <= m_scl_low_n;
      pin_reg   <= pin_next;
    end
  end

  // Outputs come straight from flops
  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign irq_o    = irq_reg;
  assign scl_o    = pin_reg.lvl;
  assign sda_o    = pin_reg.lvl;
  assign scl_oe_o = pin_reg.scl_oe;
  assign sda_oe_o = pin_reg.sda_oe;

  chk_mask_reset: assert property (@(posedge clk_i) rst_i |=> mask_reg == MASK_RST)
    else $error("mask not all ones after reset");
  chk_gc_ack_buf: assert property (@(posedge clk_i) disable iff (rst_i)
    gc_evt |=> (sl_ack || sl_hold) && rxbuf_reg == GC_ADDR && sts_reg[EV_GC])
    else $error("general call not acknowledged or not buffered");
  chk_gc_no_ua: assert property (@(posedge clk_i) disable iff (rst_i)
    gc_evt |=> sl_state == SL_DATA && !$rose(ua_reg))
    else $error("general call went to update address");
  chk_hold_scl: assert property (@(posedge clk_i) disable iff (rst_i)
    sl_hold && !start_det && !stop_det && !rel_pulse |=> sl_hold ##1 pin_reg.scl_oe)
    else $error("clock hold dropped without release");
  chk_start_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_state == M_IDLE && start_pulse && !(scl_s && sda_s)) |=> m_state == M_IDLE && sts_reg[EV_BCL])
    else $error("start on busy bus not aborted");
  chk_scl_coll: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_state == M_CNT1 && sda_s && !scl_s) |=> m_state == M_IDLE && !m_sda_low && sts_reg[EV_BCL])
    else $error("scl low in first count not a collision");
  chk_early_sda: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_state == M_CNT1 && !sda_s) |-> !bcl_evt ##1 (m_state == M_CNT2 && m_sda_low && brg_cnt == brg_reg))
    else $error("early sda not taken");
  chk_cnt2_scl: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_state == M_CNT2 && brg_cnt == 8'h00) |-> !bcl_evt ##1 m_scl_low ##1 pin_reg.scl_oe)
    else $error("scl not driven low at second count end");
endmodule

// *** gcm_sync2.sv ***
// Two-flop synchroniser for the bus pins SCL and SDA.
// Assumes the pins are asynchronous to clk_i; the output is only read as a level.
module gcm_sync2 (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Synchronous reset, active high
  input  wire logic [1:0] pin_i,   // Raw pin levels {scl, sda}
  output logic      [1:0] pin_o    // Synchronised levels
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;
  end

  // Idle bus level is high, so reset both stages to ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_o = sync_reg;
endmodule

// *** gcm_bus_model.sv ***
// Second master on the two-wire bus: makes Start/Stop, sends bytes, pulls lines.
// Assumes the bench resolves both open-drain wires with pull-ups and feeds them back.
module gcm_bus_model (
  input  wire logic clk_i,    // System clock
  input  wire logic scl_i,    // Resolved SCL wire
  input  wire logic sda_i,    // Resolved SDA wire
  output logic      scl_oe_o, // High pulls SCL low
  output logic      sda_oe_o  // High pulls SDA low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 8; // Cycles per pause; each send_byte bit takes three pauses

  // Lines released until a command arrives
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end

  task automatic pause();
    repeat (HALF) @(posedge clk_i);
  endtask

  // Bounded wait, since the slave may stretch the clock
  task automatic scl_high();
    int n;
    n = 0;
    while (scl_i !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic pull(input logic s, input logic d);
    scl_oe_o <= s;
    sda_oe_o <= d;
  endtask

  task automatic start_cond();
    sda_oe_o <= 1'b1;
    pause();
    scl_oe_o <= 1'b1;
    pause();
  endtask

  task automatic stop_cond();
    sda_oe_o <= 1'b1;
    pause();
    scl_oe_o <= 1'b0;
    scl_high();
    pause();
    sda_oe_o <= 1'b0;
    pause();
  endtask

  // MSB first; data moves only while SCL is low so no false Start/Stop
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_o <= (i > 0) ? ~b[i-1] : 1'b0;
      pause();
      scl_oe_o <= 1'b0;
      scl_high();
      pause();
      if (i == 0) ack = ~sda_i; // Sampled late in the high phase
      scl_oe_o <= 1'b1;
      pause();
    end
  endtask
endmodule

// *** i2c_gencall_mask_start_collision_tb_top.sv ***
// Self-checking bench for the general call, address mask and Start slice.
// Assumes gcm_top and gcm_bus_model; pull-ups on SCL and SDA are modelled here.
module i2c_gencall_mask_start_collision_tb_top import gcm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] ctl;
    logic [7:0] msk;
    logic [7:0] b0;
    logic [7:0] b1;
    logic       a0;
    logic       a1;
  } gcm_row_type;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, irq, scl_oe, sda_oe, m_scl_oe, m_sda_oe, a, scl_lvl, sda_lvl;
  wire         scl = ~(scl_oe | m_scl_oe); // Pull-up wins when nobody pulls
  wire         sda = ~(sda_oe | m_sda_oe);
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  gcm_row_type rows[9];

  gcm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .scl_i(scl), .scl_o(scl_lvl), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_lvl),
    .sda_oe_o(sda_oe));
  gcm_bus_model model (.clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

  always #50 clk_i = ~clk_i;

  // Hang guard, well above the roughly five thousand cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    adr <= ad;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, ad, d, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, ad, 32'h0, q);
    chk(nm, e, q);
  endtask

  task automatic st_bit(input string nm, input int b, input logic e);
    logic [31:0] q;
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(nm, {31'h0, e}, {31'h0, q[b]});
  endtask

  task automatic wait_oe(input logic on_scl, output int n);
    n = 0;
    while ((on_scl ? scl_oe : sda_oe) !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // Main sequence: table of address cases, then reset and hand-written cases
  initial begin
    int n;
    rows = '{'{3'd0, 8'hFF, 8'hA4, 8'h11, 1'b1, 1'b1}, '{3'd0, 8'hFF, 8'hA6, 8'h00, 1'b0, 1'b0},
             '{3'd0, 8'hF1, 8'hAA, 8'h22, 1'b1, 1'b1}, '{3'd0, 8'hF1, 8'hB4, 8'h00, 1'b0, 1'b0},
             '{3'd0, 8'h00, 8'h5A, 8'h33, 1'b1, 1'b1}, '{3'd1, 8'hFF, 8'h00, 8'h44, 1'b1, 1'b1},
             '{3'd4, 8'h0F, 8'hF4, 8'h55, 1'b1, 1'b1}, '{3'd4, 8'h00, 8'hF2, 8'h00, 1'b0, 1'b0},
             '{3'd4, 8'hFE, 8'hF4, 8'hA4, 1'b1, 1'b1}};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(ADR_OWN, 32'h0000_02A5);
    foreach (rows[i]) begin
      wr(ADR_CTRL, {29'h0, rows[i].ctl});
      wr(ADR_MASK, {24'h0, rows[i].msk});
      model.start_cond();
      model.send_byte(rows[i].b0, a);
      chk("first byte ack", {31'h0, rows[i].a0}, {31'h0, a});
      if (rows[i].a0) begin
        model.send_byte(rows[i].b1, a);
        chk("second byte ack", {31'h0, rows[i].a1}, {31'h0, a});
      end
      model.stop_cond();
    end
    st_bit("update flag set", ST_UA, 1'b1);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("mask", ADR_MASK, 32'h0000_00FF);
    rdc("reload", ADR_BRG, {24'h0, BRG_RST});
    rdc("int_en", ADR_INT_EN, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h40, 32'h0);
    // General call in 10-bit mode, then a data byte
    wr(ADR_OWN, 32'h0000_02A5);
    wr(ADR_CTRL, 32'h0000_0005);
    wr(ADR_INT_EN, 32'h0000_0002);
    model.start_cond();
    model.send_byte(8'h00, a);
    chk("gc ack", 32'h1, {31'h0, a});
    st_bit("gc flag", EV_GC, 1'b1);
    st_bit("update flag", ST_UA, 1'b0);
    irq_is(1'b1);
    rdc("rx gc", ADR_RXBUF, 32'h0);
    model.send_byte(8'h3C, a);
    rdc("rx data", ADR_RXBUF, 32'h0000_003C);
    st_bit("data flag", EV_DATA, 1'b1);
    model.stop_cond();
    wr(ADR_INT_CLR, 32'h0000_001F);
    irq_is(1'b0);
    // Address hold: clock stays low until software releases it
    wr(ADR_CTRL, 32'h0000_0003);
    model.start_cond();
    fork
      model.send_byte(8'h00, a);
      begin
        wait_oe(1'b1, n);
        repeat (30) @(posedge clk_i);
        chk("scl held", 32'h0, {31'h0, scl});
        st_bit("hold flag", ST_HOLD, 1'b1);
        wr(ADR_CTRL, 32'h0000_0023);
      end
    join
    chk("ack after hold", 32'h1, {31'h0, a});
    model.stop_cond();
    wr(ADR_CTRL, 32'h0);
    wr(ADR_BRG, 32'h0000_0010);
    // Start on a free bus; SCL low in the second count is ignored
    wr(ADR_CTRL, 32'h0000_0010);
    wait_oe(1'b0, n);
    chk("first count", 32'h1, {31'h0, n >= 10 && n <= 22});
    chk("scl before", 32'h0, {31'h0, scl_oe});
    model.pull(1'b1, 1'b0);
    wait_oe(1'b1, n);
    chk("second count", 32'h1, {31'h0, n >= 12 && n <= 22});
    chk("low levels", 32'h0, {30'h0, scl_lvl, sda_lvl});
    model.pull(1'b0, 1'b0);
    st_bit("no collision", EV_BCL, 1'b0);
    st_bit("start done", EV_START, 1'b1);
    wr(ADR_CTRL, 32'h0000_0040);
    wr(ADR_INT_CLR, 32'h0000_001F);
    // Start refused while SDA is already low; interrupt masked, then enabled
    model.pull(1'b0, 1'b1);
    repeat (6) @(posedge clk_i);
    wr(ADR_CTRL, 32'h0000_0010);
    repeat (4) @(posedge clk_i);
    st_bit("abort flag", EV_BCL, 1'b1);
    chk("no drive", 32'h0, {30'h0, scl_oe, sda_oe});
    st_bit("idle", ST_BUSY, 1'b0);
    irq_is(1'b0);
    wr(ADR_INT_EN, 32'h0000_0008);
    irq_is(1'b1);
    wr(ADR_INT_CLR, 32'h0000_0008);
    irq_is(1'b0);
    model.pull(1'b0, 1'b0);
    // SCL low with SDA high during the first count
    repeat (6) @(posedge clk_i);
    wr(ADR_CTRL, 32'h0000_0010);
    model.pull(1'b1, 1'b0);
    repeat (30) @(posedge clk_i);
    st_bit("scl collision", EV_BCL, 1'b1);
    chk("no drive 2", 32'h0, {30'h0, scl_oe, sda_oe});
    model.pull(1'b0, 1'b0);
    wr(ADR_INT_CLR, 32'h0000_001F);
    // SDA low during the first count: early assert, no collision
    repeat (6) @(posedge clk_i);
    wr(ADR_CTRL, 32'h0000_0010);
    model.pull(1'b0, 1'b1);
    repeat (8) @(posedge clk_i);
    chk("sda early", 32'h1, {31'h0, sda_oe});
    model.pull(1'b0, 1'b0);
    repeat (40) @(posedge clk_i);
    chk("scl late", 32'h1, {31'h0, scl_oe});
    st_bit("no collision 2", EV_BCL, 1'b0);
    wr(ADR_CTRL, 32'h0000_0040);
    wrap_up();
  end
endmodule
